/* pasr_pkg.sv */
// Purpose: Shared constants and state types for the phase accumulator synthesiser
// Assumes: 8-bit classic Wishbone register port, one 10 MHz system clock
// Notes:   Offsets are byte addresses on the 8-bit register port
package pasr_pkg;

  // ==========================================================================
  // Widths
  localparam int ACC_W   = 20;
  localparam int DAT_W   = 8;
  localparam int ADR_W   = 4;
  localparam int SRC_N   = 6;
  localparam int PCNT_W  = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [ADR_W-1:0] OFS_SYNTH_CONTROL = 4'h0;
  localparam logic [ADR_W-1:0] OFS_CLOCK_CONTROL = 4'h1;
  localparam logic [ADR_W-1:0] OFS_ACC_LOW       = 4'h2;
  localparam logic [ADR_W-1:0] OFS_ACC_HIGH      = 4'h3;
  localparam logic [ADR_W-1:0] OFS_ACC_UPPER     = 4'h4;
  localparam logic [ADR_W-1:0] OFS_INC_LOW       = 4'h5;
  localparam logic [ADR_W-1:0] OFS_INC_HIGH      = 4'h6;
  localparam logic [ADR_W-1:0] OFS_INC_UPPER     = 4'h7;
  localparam logic [ADR_W-1:0] OFS_STATUS        = 4'h8;

  // ==========================================================================
  // Field positions
  localparam int CTL_ENABLE_BIT   = 7;
  localparam int CTL_OUTPUT_BIT   = 5;
  localparam int CTL_POLARITY_BIT = 4;
  localparam int CTL_PULSE_BIT    = 0;
  localparam int CLK_PWS_LSB      = 5;
  localparam int CLK_CKS_LSB      = 0;
  localparam int STS_FLAG_BIT     = 0;
  localparam logic [DAT_W-1:0] CLK_CTRL_MASK = 8'hE7;
  localparam logic [DAT_W-1:0] UPPER_MASK    = 8'h0F;

  // ==========================================================================
  // Reset values
  localparam logic [DAT_W-1:0] RST_CLOCK_CONTROL = 8'h00;
  localparam logic [ACC_W-1:0] RST_ACC           = 20'h00000;
  localparam logic [ACC_W-1:0] RST_INC           = 20'h00001;
  localparam logic [PCNT_W-1:0] PCNT_ONE         = 8'h01;

  // ==========================================================================
  // Input clock source codes
  typedef enum logic [2:0] {
    PASR_SRC_SYS_OSC   = 3'h0,
    PASR_SRC_FAST_OSC  = 3'h1,
    PASR_SRC_CELL_ONE  = 3'h2,
    PASR_SRC_CELL_TWO  = 3'h3,
    PASR_SRC_CELL_THR  = 3'h4,
    PASR_SRC_CELL_FOUR = 3'h5
  } pasr_src_e;

  // Synchroniser state
  typedef struct packed {
    logic [SRC_N-1:0] stage1;
    logic [SRC_N-1:0] stage2;
  } pasr_sync_s;

  // Wishbone slave outputs
  typedef struct packed {
    logic             ack;
    logic [DAT_W-1:0] dat;
  } pasr_wb_s;

  // Whole synthesiser state
  typedef struct packed {
    pasr_wb_s          wb;
    logic              enable;
    logic              polarity;
    logic              pulse_mode;
    logic [2:0]        pulse_width_select;
    logic [2:0]        input_clock_select;
    logic [ACC_W-1:0]  phase_accumulator;
    logic [ACC_W-1:0]  step_increment;
    logic [ACC_W-1:0]  increment_shadow;
    logic              load_pending;
    logic              clk_prev;
    logic [PCNT_W-1:0] pulse_count;
    logic              raw_out;
    logic              synth_out;
    logic              overflow_irq_flag;
  } pasr_state_s;

endpackage

/* pasr_sync.sv */
// Purpose: Two-stage synchroniser for the candidate input clock pins
// Assumes: Inputs are asynchronous to clk
// Notes:   Only stage2 is visible to the rest of the design
`timescale 1ns/100ps
`default_nettype none
module pasr_sync
  import pasr_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [SRC_N-1:0] async_in,
  output var  logic [SRC_N-1:0] sync_out
);

  pasr_sync_s state_reg;
  pasr_sync_s state_next;

  // ==========================================================================
  // Next state: shift each pin through two flops
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;

endmodule
`default_nettype wire

/* pasr_top.sv */
// Purpose: Register file and core of a 20-bit phase accumulator synthesiser
// Assumes: Input clock sources are slow against clk and are sampled through
//          two flops; edges of the selected source drive the core
// Notes:   Classic Wishbone slave with 8-bit data, answers every access
//
// What this block does
// - Pulse width code n keeps output active for 2^n input clock periods.
// - Clock select: 0 system osc, 1 fast osc, 2..5 cells, 6..7 reserved.
// - Pulse width applies only in pulse mode, ignored in fixed duty mode.
// - Accumulator readable and writable as low, high and upper byte registers.
// - Accumulator bytes show the running value live; multi-byte reads not atomic.
// - Increment held in low, high and upper byte registers, readable and writable.
// - Increment copied to shadow at next input clock falling edge after low write; at once while disabled.
// - Reset clears control and accumulator; increment resets to one.
// - Unimplemented clock control and upper byte bits read as zero.
// - Each input clock rising edge adds shadow increment; carry is overflow.
// - Fixed duty mode toggles the output on every overflow.
// - Pulse mode drives output active after overflow for the selected width.
// - Every overflow sets a sticky flag cleared by software.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pasr_top
  import pasr_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic             wb_sel_i,
  input  wire logic [DAT_W-1:0] wb_dat_i,
  output var  logic [DAT_W-1:0] wb_dat_o,
  output var  logic             wb_ack_o,
  input  wire logic             sys_osc_in,
  input  wire logic             internal_fast_osc,
  input  wire logic             logic_cell_one_output,
  input  wire logic             logic_cell_two_output,
  input  wire logic             logic_cell_three_output,
  input  wire logic             logic_cell_four_output,
  output var  logic             synth_out,
  output var  logic             overflow_irq_flag
);

  pasr_state_s      state_reg;
  pasr_state_s      state_next;
  logic [SRC_N-1:0] src_sync;
  logic             synth_input_clock;
  logic             clk_valid;
  logic             rise_edge;
  logic             fall_edge;
  logic [ACC_W:0]   sum;
  logic             accumulator_carry;
  logic             bus_req;
  logic             bus_wr;
  logic [DAT_W-1:0] rd_data;

  // ==========================================================================
  // Source pin synchroniser
  pasr_sync u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({logic_cell_four_output, logic_cell_three_output,
                logic_cell_two_output, logic_cell_one_output,
                internal_fast_osc, sys_osc_in}),
    .sync_out (src_sync)
  );

  // ==========================================================================
  // Input clock selection
  always_comb begin
    synth_input_clock = 1'b0;
    clk_valid         = 1'b1;
    case (state_reg.input_clock_select)
      PASR_SRC_SYS_OSC:   synth_input_clock = src_sync[0];
      PASR_SRC_FAST_OSC:  synth_input_clock = src_sync[1];
      PASR_SRC_CELL_ONE:  synth_input_clock = src_sync[2];
      PASR_SRC_CELL_TWO:  synth_input_clock = src_sync[3];
      PASR_SRC_CELL_THR:  synth_input_clock = src_sync[4];
      PASR_SRC_CELL_FOUR: synth_input_clock = src_sync[5];
      default: begin
        synth_input_clock = 1'b0;
        clk_valid         = 1'b0;
      end
    endcase
  end

  // Edge detection on the selected source, only while running
  assign rise_edge = state_reg.enable & clk_valid & synth_input_clock & ~state_reg.clk_prev;
  assign fall_edge = state_reg.enable & clk_valid & ~synth_input_clock & state_reg.clk_prev;

  // Adder with carry out
  assign sum = {1'b0, state_reg.phase_accumulator} + {1'b0, state_reg.increment_shadow};
  assign accumulator_carry = rise_edge & sum[ACC_W];

  // ==========================================================================
  // Bus decode: one access per request, answered one cycle later
  assign bus_req = wb_cyc_i & wb_stb_i & ~state_reg.wb.ack;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i;

  // Read multiplexer
  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      OFS_SYNTH_CONTROL: begin
        rd_data[CTL_ENABLE_BIT]   = state_reg.enable;
        rd_data[CTL_OUTPUT_BIT]   = state_reg.synth_out;
        rd_data[CTL_POLARITY_BIT] = state_reg.polarity;
        rd_data[CTL_PULSE_BIT]    = state_reg.pulse_mode;
      end
      OFS_CLOCK_CONTROL: begin
        rd_data[CLK_PWS_LSB +: 3] = state_reg.pulse_width_select;
        rd_data[CLK_CKS_LSB +: 3] = state_reg.input_clock_select;
      end
      OFS_ACC_LOW:   rd_data = state_reg.phase_accumulator[7:0];
      OFS_ACC_HIGH:  rd_data = state_reg.phase_accumulator[15:8];
      OFS_ACC_UPPER: rd_data = {4'h0, state_reg.phase_accumulator[19:16]};
      OFS_INC_LOW:   rd_data = state_reg.step_increment[7:0];
      OFS_INC_HIGH:  rd_data = state_reg.step_increment[15:8];
      OFS_INC_UPPER: rd_data = {4'h0, state_reg.step_increment[19:16]};
      OFS_STATUS:    rd_data[STS_FLAG_BIT] = state_reg.overflow_irq_flag;
      default:       rd_data = '0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    state_next          = state_reg;
    state_next.clk_prev = synth_input_clock;

    // Bus handshake and read data capture
    state_next.wb.ack = bus_req;
    if (bus_req) begin
      state_next.wb.dat = rd_data;
    end

    // Core: accumulate on each rising edge of the selected clock
    if (rise_edge) begin
      state_next.phase_accumulator = sum[ACC_W-1:0];
    end

    // Output shaping by mode
    if (accumulator_carry) begin
      if (state_reg.pulse_mode) begin
        state_next.raw_out     = 1'b1;
        state_next.pulse_count = PCNT_ONE << state_reg.pulse_width_select;
      end else begin
        state_next.raw_out = ~state_reg.raw_out;
      end
    end else if (rise_edge && state_reg.pulse_mode && state_reg.raw_out) begin
      // Count input periods of the active pulse
      if (state_reg.pulse_count <= PCNT_ONE) begin
        state_next.raw_out     = 1'b0;
        state_next.pulse_count = '0;
      end else begin
        state_next.pulse_count = state_reg.pulse_count - PCNT_ONE;
      end
    end

    // Shadow copy on falling edge after a low byte write
    if (fall_edge && state_reg.load_pending) begin
      state_next.increment_shadow = state_reg.step_increment;
      state_next.load_pending     = 1'b0;
    end

    // Register writes
    if (bus_wr) begin
      case (wb_adr_i)
        OFS_SYNTH_CONTROL: begin
          state_next.enable     = wb_dat_i[CTL_ENABLE_BIT];
          state_next.polarity   = wb_dat_i[CTL_POLARITY_BIT];
          state_next.pulse_mode = wb_dat_i[CTL_PULSE_BIT];
          if (!wb_dat_i[CTL_ENABLE_BIT]) begin
            state_next.raw_out     = 1'b0;
            state_next.pulse_count = '0;
          end
        end
        OFS_CLOCK_CONTROL: begin
          state_next.pulse_width_select = wb_dat_i[CLK_PWS_LSB +: 3];
          state_next.input_clock_select = wb_dat_i[CLK_CKS_LSB +: 3];
        end
        OFS_ACC_LOW:   state_next.phase_accumulator[7:0]   = wb_dat_i;
        OFS_ACC_HIGH:  state_next.phase_accumulator[15:8]  = wb_dat_i;
        OFS_ACC_UPPER: state_next.phase_accumulator[19:16] = wb_dat_i[3:0];
        OFS_INC_LOW: begin
          state_next.step_increment[7:0] = wb_dat_i;
          if (state_reg.enable) begin
            state_next.load_pending = 1'b1;
          end
        end
        OFS_INC_HIGH:  state_next.step_increment[15:8]  = wb_dat_i;
        OFS_INC_UPPER: state_next.step_increment[19:16] = wb_dat_i[3:0];
        default: begin
          state_next.load_pending = state_next.load_pending;
        end
      endcase

      // Disabled: any increment write reaches the shadow at once
      if (!state_reg.enable &&
          (wb_adr_i == OFS_INC_LOW || wb_adr_i == OFS_INC_HIGH ||
           wb_adr_i == OFS_INC_UPPER)) begin
        state_next.increment_shadow = state_next.step_increment;
        state_next.load_pending     = 1'b0;
      end
    end

    // Sticky overflow flag: write one clears, a new overflow wins
    if (bus_wr && wb_adr_i == OFS_STATUS && wb_dat_i[STS_FLAG_BIT]) begin
      state_next.overflow_irq_flag = 1'b0;
    end
    if (accumulator_carry) begin
      state_next.overflow_irq_flag = 1'b1;
    end

    // Polarity stage and output flop
    state_next.synth_out = state_next.raw_out ^ state_next.polarity;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg                    <= '0;
      state_reg.pulse_width_select <= RST_CLOCK_CONTROL[CLK_PWS_LSB +: 3];
      state_reg.input_clock_select <= RST_CLOCK_CONTROL[CLK_CKS_LSB +: 3];
      state_reg.phase_accumulator  <= RST_ACC;
      state_reg.step_increment     <= RST_INC;
      state_reg.increment_shadow   <= RST_INC;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs straight from the state flops
  assign wb_dat_o          = state_reg.wb.dat;
  assign wb_ack_o          = state_reg.wb.ack;
  assign synth_out         = state_reg.synth_out;
  assign overflow_irq_flag = state_reg.overflow_irq_flag;

endmodule
`default_nettype wire

/* pasr_top_assertions.sv */
// Purpose: Bus and flag checks for the synthesiser register port
// Assumes: Sees only the ports of pasr_top
// Notes:   Bound to every instance of pasr_top
`timescale 1ns/100ps
`default_nettype none
module pasr_top_assertions
  import pasr_pkg::*;
(
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic             wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             overflow_irq_flag
);
  // ==========================================================================
  // Request decode
  logic req;
  logic rd_ccr;
  logic rd_up;
  logic rd_map;
  logic clr_req;
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_ccr  = req && !wb_we_i && wb_adr_i == OFS_CLOCK_CONTROL;
  assign rd_up   = req && !wb_we_i && (wb_adr_i == OFS_ACC_UPPER || wb_adr_i == OFS_INC_UPPER);
  assign rd_map  = req && !wb_we_i && wb_adr_i > OFS_STATUS;
  assign clr_req = req && wb_we_i && wb_sel_i && wb_adr_i == OFS_STATUS && wb_dat_i[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Assertions
  ack_answer_a: assert property (req |=> wb_ack_o) else $error("request not acked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
  dat_hold_a: assert property (!req |=> $stable(wb_dat_o)) else $error("read data moved");
  ccr_zero_a: assert property (wb_ack_o && $past(rd_ccr) |-> wb_dat_o[4:3] == 2'h0)
    else $error("clock control bits 4-3 not zero");
  upper_zero_a: assert property (wb_ack_o && $past(rd_up) |-> wb_dat_o[7:4] == 4'h0)
    else $error("upper byte bits 7-4 not zero");
  unmap_zero_a: assert property (wb_ack_o && $past(rd_map) |-> wb_dat_o == 8'h00)
    else $error("unmapped read not zero");
  flag_hold_a: assert property (overflow_irq_flag && !clr_req |=> overflow_irq_flag)
    else $error("flag dropped without clear");
  flag_clear_a: assert property ($fell(overflow_irq_flag) |-> $past(clr_req))
    else $error("flag fell without clear");

  // Main scenarios
  write_c: cover property (req && wb_we_i);
  read_c: cover property (req && !wb_we_i);
  flag_c: cover property ($rose(overflow_irq_flag));
endmodule

bind pasr_top pasr_top_assertions pasr_top_assertions_i (
  .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .overflow_irq_flag(overflow_irq_flag)
);
`default_nettype wire

/* tb_pasr_top.sv */
// Purpose: Self-checking bench for the synthesiser register block
// Assumes: Source pins toggle slowly, 4 clk high and at least 7 clk low
// Notes:   Accumulator written only while the synthesiser is disabled
`timescale 1ns/100ps
`default_nettype none
module tb_pasr_top
  import pasr_pkg::*;
;
  logic             clk, nrst, cyc, stb, we, sel, ack, sout, flag;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] wdat, rdat, rd;
  logic [SRC_N-1:0] pins;
  int               n_errors, cmp_count;

  // ==========================================================================
  // Device under test
  pasr_top pasr_top_i (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sys_osc_in(pins[0]), .internal_fast_osc(pins[1]),
    .logic_cell_one_output(pins[2]), .logic_cell_two_output(pins[3]),
    .logic_cell_three_output(pins[4]), .logic_cell_four_output(pins[5]),
    .synth_out(sout), .overflow_irq_flag(flag));

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  task automatic give_verdict();
    $display("Counts: %0d mismatches in %0d compares", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: no ack", $time);
    end
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
    wb(1'b0, a, 8'h00);
    chk8(rd, e);
  endtask

  // Upper and high first, low last
  task automatic set_inc(input logic [ACC_W-1:0] v);
    wr(OFS_INC_UPPER, {4'h0, v[19:16]});
    wr(OFS_INC_HIGH, v[15:8]);
    wr(OFS_INC_LOW, v[7:0]);
  endtask

  // Callers keep the synthesiser disabled here
  task automatic set_acc(input logic [ACC_W-1:0] v);
    wr(OFS_ACC_UPPER, {4'h0, v[19:16]});
    wr(OFS_ACC_HIGH, v[15:8]);
    wr(OFS_ACC_LOW, v[7:0]);
  endtask

  task automatic chk_acc(input logic [ACC_W-1:0] v);
    rdc(OFS_ACC_LOW, v[7:0]);
    rdc(OFS_ACC_HIGH, v[15:8]);
    rdc(OFS_ACC_UPPER, {4'h0, v[19:16]});
  endtask

  task automatic pulse(input int p, input int k);
    repeat (k) begin
      @(posedge clk);
      pins[p] <= 1'b1;
      repeat (4) @(posedge clk);
      pins[p] <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    for (int a = 0; a < 10; a++) rdc(a[3:0], (a == 5) ? 8'h01 : 8'h00);
    wr(OFS_CLOCK_CONTROL, 8'hFF);
    rdc(OFS_CLOCK_CONTROL, 8'hE7);
    wr(OFS_ACC_UPPER, 8'hFF);
    rdc(OFS_ACC_UPPER, 8'h0F);
    wr(OFS_INC_UPPER, 8'hFF);
    rdc(OFS_INC_UPPER, 8'h0F);
    sel <= 1'b0;
    wr(OFS_CLOCK_CONTROL, 8'h00);
    sel <= 1'b1;
    rdc(OFS_CLOCK_CONTROL, 8'hE7);
    wr(OFS_CLOCK_CONTROL, 8'h00);
    set_acc(20'h00000);
    $display("test reset done");
  endtask

  task automatic t_sources();
    logic [ACC_W-1:0] e;
    e = 20'h00000;
    set_inc(20'h00011);
    wr(OFS_SYNTH_CONTROL, 8'h80);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CLOCK_CONTROL, {5'h00, c[2:0]});
      pulse((c + 1) % 6, 1);
      chk_acc(e);
      pulse(c % 6, 1);
      if (c < 6) e = e + 20'h00011;
      chk_acc(e);
    end
    $display("test sources done");
  endtask

  task automatic t_fdc();
    wr(OFS_SYNTH_CONTROL, 8'h00);
    set_acc(20'h00000);
    set_inc(20'h80000);
    wr(OFS_CLOCK_CONTROL, 8'hE0);
    wr(OFS_SYNTH_CONTROL, 8'h80);
    pulse(0, 1);
    chk8({6'h00, sout, flag}, 8'h00);
    pulse(0, 1);
    chk8({6'h00, sout, flag}, 8'h03);
    pulse(0, 2);
    chk8({6'h00, sout, flag}, 8'h01);
    chk_acc(20'h00000);
    wr(OFS_STATUS, 8'h01);
    rdc(OFS_STATUS, 8'h00);
    chk8({7'h00, flag}, 8'h00);
    // Polarity inverts the output and shows in the control readback
    wr(OFS_SYNTH_CONTROL, 8'h90);
    rdc(OFS_SYNTH_CONTROL, 8'hB0);
    chk8({7'h00, sout}, 8'h01);
    $display("test fixed duty done");
  endtask

  task automatic t_pulse();
    for (int p = 0; p < 2; p++) begin
      wr(OFS_SYNTH_CONTROL, 8'h00);
      set_acc(20'h00000);
      set_inc(20'h40000);
      // Width of 1 or 2 periods stays below the 4-period overflow
      wr(OFS_CLOCK_CONTROL, {p[2:0], 5'h00});
      wr(OFS_SYNTH_CONTROL, 8'h81);
      pulse(0, 3);
      chk8({7'h00, sout}, 8'h00);
      pulse(0, 1);
      chk8({7'h00, sout}, 8'h01);
      pulse(0, 1);
      chk8({7'h00, sout}, p[7:0]);
      pulse(0, 2);
      chk8({7'h00, sout}, 8'h00);
    end
    $display("test pulse mode done");
  endtask

  task automatic t_shadow();
    wr(OFS_SYNTH_CONTROL, 8'h00);
    set_acc(20'h00000);
    set_inc(20'h00010);
    wr(OFS_CLOCK_CONTROL, 8'h00);
    wr(OFS_SYNTH_CONTROL, 8'h80);
    pulse(0, 1);
    set_inc(20'h12300);
    pulse(0, 1);
    chk_acc(20'h00020);
    pulse(0, 1);
    chk_acc(20'h12320);
    $display("test shadow done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {nrst, cyc, stb, we, adr, wdat, pins} = '0;
    sel = 1'b1;
    n_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_sources();
    t_fdc();
    t_pulse();
    t_shadow();
    give_verdict();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
